// ### src/prs_regs.svh
// prs_regs.svh: timing counts and reset values of the power-up and reset sequencer.
// assumes a 250 MHz core clock; included by the package, the sequencer and the monitor.
`ifndef PRS_REGS_SVH
`define PRS_REGS_SVH

`define PRS_CLK_PERIOD_PS 4000
// longest self-initialization time, in microseconds
`define PRS_POWERUP_WAIT_US 150
// longest time rounds down to whole cycles
`define PRS_POWERUP_WAIT_CYC ((`PRS_POWERUP_WAIT_US * 1000000) / `PRS_CLK_PERIOD_PS)
`define PRS_CNT_W 16
`define PRS_ROW_W 13
`define PRS_ROW_RESET 13'h0000
`define PRS_CFG0_RESET 16'h8F1F
`define PRS_CFG1_RESET 16'h0002
// the device-side refresh interval between row refreshes, in cycles
`define PRS_REFRESH_GAP_CYC 16'h0100

`endif

// ### src/prs_pkg.sv
// prs_pkg.sv: types of the power-up and reset sequencer.
// assumes prs_regs.svh is on the include path.
package prs_pkg;
    `include "prs_regs.svh"

    // sequencer states, one-hot
    typedef enum logic [3:0] {
        PRS_ST_RESET = 4'h1,
        PRS_ST_INIT = 4'h2,
        PRS_ST_STANDBY = 4'h4,
        PRS_ST_SLEEP = 4'h8
    } prs_state_e;

    // low-power sleep kinds
    typedef enum logic [1:0] {
        PRS_SLP_NONE = 2'h0,
        PRS_SLP_RETENTION = 2'h1,
        PRS_SLP_DEEPEST = 2'h2
    } prs_sleep_e;

    typedef logic [`PRS_CNT_W-1:0] prs_cnt_t;
    typedef logic [`PRS_ROW_W-1:0] prs_row_t;

    typedef struct packed {
        prs_state_e state;
        prs_sleep_e sleep;
        logic [17:0] init_cnt;
        prs_cnt_t gap_cnt;
        prs_row_t row;
        logic refresh_on;
        logic refresh_pulse;
        logic array_valid;
        logic ready;
        logic [15:0] cfg0;
        logic [15:0] cfg1;
    } prs_state_s;
endpackage

// ### src/prs_sequencer.sv
// prs_sequencer.sv: device-side power-up initialization and hardware-reset sequencing.
// assumes all inputs synchronous to core_clk_i; rst_n_i is the power-on reset of the core
// and hw_reset_n_i is the host's reset pin, already synchronous.
// the host is trusted to keep its reset pulse and select waits; only config writes are
// gated on select_n_i, so a host that breaks those waits is not caught in here.

// widths, counts and reset values come from the shared header
`include "prs_regs.svh"

module prs_sequencer (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic hw_reset_n_i,
    input wire logic select_n_i,
    input wire logic sleep_req_i,
    input wire prs_pkg::prs_sleep_e sleep_kind_i,
    input wire logic cfg_we_i,
    input wire logic cfg_sel_i,
    input wire logic [15:0] cfg_wdata_i,
    output logic ready_o,
    output logic refresh_on_o,
    output logic refresh_pulse_o,
    output logic [`PRS_ROW_W-1:0] refresh_row_o,
    output logic array_valid_o,
    output prs_pkg::prs_sleep_e sleep_state_o,
    output logic [15:0] cfg0_o,
    output logic [15:0] cfg1_o
);
    import prs_pkg::*;

    // last cycle of the init count; rounding down keeps the wait inside the maximum
    localparam logic [17:0] INIT_LAST = 18'(`PRS_POWERUP_WAIT_CYC - 1);

    // helpers shared by the next-state logic; each keeps one decision in one place so the
    // refresh, init and request paths cannot drift apart when a count or width changes

    // true on the last cycle of a refresh gap, when the next row is due
    function automatic logic gap_wrap(input prs_cnt_t gap);
        return gap == (`PRS_REFRESH_GAP_CYC - 16'h0001);
    endfunction

    // gap counter one cycle further; it is cleared at the wrap, never left to overflow
    function automatic prs_cnt_t gap_step(input prs_cnt_t gap);
        return gap + prs_cnt_t'(1);
    endfunction

    // next refresh row; the counter wraps over the whole row space on purpose,
    // as self-refresh simply sweeps the array again
    function automatic prs_row_t row_step(input prs_row_t row);
        return row + prs_row_t'(1);
    endfunction

    // true once the self-initialization count has reached its last cycle
    function automatic logic init_done(input logic [17:0] cnt);
        return cnt == INIT_LAST;
    endfunction

    // init counter one cycle further; it stops at INIT_LAST, so 18 bits never overflow
    function automatic logic [17:0] init_step(input logic [17:0] cnt);
        return cnt + 18'h00001;
    endfunction

    // a host config write counts only with the strobe up and the device selected;
    // a strobe seen while deselected is host noise and is dropped without a sign
    function automatic logic cfg_write_ok(input logic we, input logic sel_n);
        return we && !sel_n;
    endfunction

    // only retention or deepest sleep is a real request; any other code is dropped
    // rather than parking the sequencer in a sleep state it cannot report
    function automatic logic sleep_real(input prs_sleep_e kind);
        return kind == PRS_SLP_RETENTION || kind == PRS_SLP_DEEPEST;
    endfunction

    // deepest sleep powers the array down, so its contents stop being valid
    function automatic logic sleep_drops_array(input prs_sleep_e kind);
        return kind == PRS_SLP_DEEPEST;
    endfunction

    // one packed image of all state; the registered copy drives every output
    prs_state_s state_reg;
    prs_state_s state_next;

    // sequencing in brief: RESET holds while the host reset pin is low, INIT counts the
    // self-initialization time from its release, STANDBY takes config writes and sleep
    // requests, SLEEP waits for the next hardware reset, its only way out. refresh runs
    // in every state once the pin is high, so INIT doubles as the array warm-up sweep.

    // next-state logic; hw reset takes priority over every other event
    always_comb begin
        state_next = state_reg;
        state_next.refresh_pulse = 1'b0;
        // pin low: everything goes back to its default at once
        if (!hw_reset_n_i) begin
            state_next.state = PRS_ST_RESET;
            state_next.cfg0 = `PRS_CFG0_RESET;
            state_next.cfg1 = `PRS_CFG1_RESET;
            state_next.refresh_on = 1'b0;
            state_next.array_valid = 1'b0;
            state_next.sleep = PRS_SLP_NONE;
            state_next.row = `PRS_ROW_RESET;
            state_next.gap_cnt = '0;
            state_next.init_cnt = '0;
            state_next.ready = 1'b0;
        end else begin
            // refresh runs in every state once reset is high
            state_next.refresh_on = 1'b1;
            // one row is refreshed at the end of every gap
            if (gap_wrap(state_reg.gap_cnt)) begin
                state_next.gap_cnt = '0;
                state_next.refresh_pulse = 1'b1;
                state_next.row = row_step(state_reg.row);
            end else begin
                state_next.gap_cnt = gap_step(state_reg.gap_cnt);
            end

            // sequencing proper
            case (state_reg.state)
                PRS_ST_RESET: begin
                    // init period starts only now that reset is high
                    state_next.state = PRS_ST_INIT;
                    state_next.init_cnt = '0;
                end
                PRS_ST_INIT: begin
                    // init is counted from reset release; no access until it ends
                    if (init_done(state_reg.init_cnt)) begin
                        state_next.state = PRS_ST_STANDBY;
                        state_next.ready = 1'b1;
                        state_next.array_valid = 1'b1;
                    end else begin
                        state_next.init_cnt = init_step(state_reg.init_cnt);
                    end
                end
                PRS_ST_STANDBY: begin
                    // config writes land only in standby, never while reset is low
                    if (cfg_write_ok(cfg_we_i, select_n_i)) begin
                        if (cfg_sel_i) begin
                            state_next.cfg1 = cfg_wdata_i;
                        end else begin
                            state_next.cfg0 = cfg_wdata_i;
                        end
                    end

                    // only a real sleep kind is honoured
                    if (sleep_req_i && sleep_real(sleep_kind_i)) begin
                        state_next.state = PRS_ST_SLEEP;
                        state_next.sleep = sleep_kind_i;
                        state_next.ready = 1'b0;
                        if (sleep_drops_array(sleep_kind_i)) begin
                            // deepest sleep drops the array
                            state_next.array_valid = 1'b0;
                        end
                    end
                end
                PRS_ST_SLEEP: begin
                    // only a hardware reset leaves sleep here; no access while asleep
                    state_next.state = PRS_ST_SLEEP;
                    state_next.ready = 1'b0;
                end
                default: begin
                    // a damaged state code must never leave ready up: restart from reset
                    // and run the full self-initialization again
                    state_next.state = PRS_ST_RESET;
                    state_next.sleep = PRS_SLP_NONE;
                    state_next.init_cnt = '0;
                    state_next.ready = 1'b0;
                    state_next.array_valid = 1'b0;
                end
            endcase
        end
    end

    // state register; a core reset looks like a held hardware reset, so both resets
    // leave the same image and the core can never start in a half-set state
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg.state <= PRS_ST_RESET;
            state_reg.sleep <= PRS_SLP_NONE;
            state_reg.init_cnt <= '0;
            state_reg.gap_cnt <= '0;
            state_reg.row <= `PRS_ROW_RESET;
            state_reg.refresh_on <= 1'b0;
            state_reg.refresh_pulse <= 1'b0;
            state_reg.array_valid <= 1'b0;
            state_reg.ready <= 1'b0;
            state_reg.cfg0 <= `PRS_CFG0_RESET;
            state_reg.cfg1 <= `PRS_CFG1_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from the state flops, so the host sees no combinational glitch
    assign ready_o = state_reg.ready;

    // refresh status
    assign refresh_on_o = state_reg.refresh_on;
    assign refresh_pulse_o = state_reg.refresh_pulse;
    assign refresh_row_o = state_reg.row;

    // array and sleep status
    assign array_valid_o = state_reg.array_valid;
    assign sleep_state_o = state_reg.sleep;

    // configuration registers
    assign cfg0_o = state_reg.cfg0;
    assign cfg1_o = state_reg.cfg1;
endmodule

// ### verification/prs_sequencer_monitor.sv
// prs_sequencer_monitor.sv: port assertions of the sequencer.
// assumes one clock domain; bound to every prs_sequencer.
`include "prs_regs.svh"
module prs_mon (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic hw_reset_n_i,
    input wire logic ready_o,
    input wire logic refresh_on_o,
    input wire logic refresh_pulse_o,
    input wire logic [`PRS_ROW_W-1:0] refresh_row_o,
    input wire logic array_valid_o,
    input wire prs_pkg::prs_sleep_e sleep_state_o,
    input wire logic [15:0] cfg0_o,
    input wire logic [15:0] cfg1_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import prs_pkg::*;
    logic [17:0] wait_reg;
    // cycles waited for ready since the reset pin went high; sleep drops ready on purpose
    // and must not read as a slow init, so the count rests at zero while asleep
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) wait_reg <= 18'h00000;
        else if (hw_reset_n_i && !ready_o && sleep_state_o == PRS_SLP_NONE)
            wait_reg <= wait_reg + 18'h00001;
        else wait_reg <= 18'h00000;
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence rel_s;
        !hw_reset_n_i ##1 hw_reset_n_i;
    endsequence
    AST_INIT_MAX: assert property (wait_reg <= 18'h0927E) else $error("init too long");
    AST_INIT_MIN: assert property ($rose(ready_o) |-> wait_reg >= 18'h0927B)
        else $error("init too short");
    AST_HOLD: assert property (!hw_reset_n_i |=> !ready_o) else $error("ready in reset");
    AST_CFG: assert property (!hw_reset_n_i |=> cfg0_o == `PRS_CFG0_RESET &&
        cfg1_o == `PRS_CFG1_RESET) else $error("config not default");
    AST_STOP: assert property (!hw_reset_n_i |=> !refresh_on_o && !array_valid_o)
        else $error("refresh in reset");
    AST_SLEEP: assert property (!hw_reset_n_i |=> sleep_state_o == PRS_SLP_NONE)
        else $error("sleep kept");
    AST_RESUME: assert property (rel_s |=> refresh_on_o && refresh_row_o == `PRS_ROW_RESET)
        else $error("refresh not restarted");
    AST_ROW: assert property (refresh_pulse_o && $past(refresh_on_o) |->
        refresh_row_o == $past(refresh_row_o) + 13'h0001) else $error("row step");
    AST_READY: assert property (ready_o |-> $past(hw_reset_n_i) && refresh_on_o)
        else $error("ready wrong");
endmodule
bind prs_sequencer prs_mon u_mon (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .hw_reset_n_i(hw_reset_n_i), .ready_o(ready_o), .refresh_on_o(refresh_on_o),
    .refresh_pulse_o(refresh_pulse_o), .refresh_row_o(refresh_row_o),
    .array_valid_o(array_valid_o), .sleep_state_o(sleep_state_o), .cfg0_o(cfg0_o),
    .cfg1_o(cfg1_o));

// ### verification/prs_host_model.sv
// prs_host_model.sv: host driving the reset pin and chip select.
// assumes the sequencer's ready output and the 250 MHz clock.
module prs_host_model #(
    parameter int LOW_CYC = 50,
    parameter int RH_CYC = 50,
    parameter int RPH_CYC = 100
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic reset_req_i,
    input wire logic ready_i,
    output logic hw_reset_n_o,
    output logic select_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_reg;
    // saturating count from the last reset, so every wait stays met
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= 8'h00;
            hw_reset_n_o <= 1'b0; // low through power-up
        end else if (reset_req_i) begin
            cnt_reg <= 8'h00;
            hw_reset_n_o <= 1'b0;
        end else begin
            cnt_reg <= (cnt_reg == 8'hFF) ? cnt_reg : cnt_reg + 8'h01;
            hw_reset_n_o <= hw_reset_n_o | (cnt_reg >= LOW_CYC);
        end
    end
    // deselected until both waits ran out and the device is ready
    assign select_n_o = !(hw_reset_n_o && ready_i && cnt_reg >= LOW_CYC + RH_CYC
        && cnt_reg >= RPH_CYC);
endmodule

// ### verification/psram_reset_powerup_sequencing_bench.sv
// psram_reset_powerup_sequencing_bench.sv: self-checking bench of the sequencer.
// assumes the package, the host model and the monitor are compiled first.
module psram_reset_powerup_sequencing_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import prs_pkg::*;
    logic core_clk_i = 1'b0, rst_n_i = 1'b0, sleep_req = 1'b0, cfg_we = 1'b0, cfg_sel = 1'b0;
    logic reset_req = 1'b0, hw_reset_n, select_n, ready, ron, aval;
    logic [15:0] cfg_wdata = 16'h0000, cfg0, cfg1;
    logic [12:0] row;
    prs_sleep_e sleep_kind = PRS_SLP_NONE, slp;
    logic [31:0] exp_q[$], prev = 32'h00028F1F, cur = 32'h00028F1F;
    int failures = 0, cmp_count = 0, seed = 62983, n;
    always #2 core_clk_i = ~core_clk_i;
    prs_host_model host (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reset_req_i(reset_req),
        .ready_i(ready), .hw_reset_n_o(hw_reset_n), .select_n_o(select_n));
    prs_sequencer DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .hw_reset_n_i(hw_reset_n),
        .select_n_i(select_n), .sleep_req_i(sleep_req), .sleep_kind_i(sleep_kind),
        .cfg_we_i(cfg_we), .cfg_sel_i(cfg_sel), .cfg_wdata_i(cfg_wdata), .ready_o(ready),
        .refresh_on_o(ron), .refresh_pulse_o(), .refresh_row_o(row), .array_valid_o(aval),
        .sleep_state_o(slp), .cfg0_o(cfg0), .cfg1_o(cfg1));
    task automatic results();
        if (failures == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic ok);
        cmp_count++;
        if (ok !== 1'b1) begin
            failures++;
            $display("unexpected at %0t: port value", $time);
        end
    endtask
    // edges from reset pin release to ready
    task automatic wait_ready();
        n = 0;
        wait (hw_reset_n === 1'b1);
        while (ready !== 1'b1 && n < 40000) begin
            @(posedge core_clk_i);
            #1;
            n++;
        end
        chk(n >= 37500 && n <= 37502 && aval === 1'b1 && ron === 1'b1);
    endtask
    task automatic cfg_wr(input logic sel, input logic ok);
        @(posedge core_clk_i);
        cfg_we <= 1'b1;
        cfg_sel <= sel;
        cfg_wdata <= 16'($random(seed));
        #1;
        if (sel) cur[31:16] = ok ? cfg_wdata : cur[31:16];
        else cur[15:0] = ok ? cfg_wdata : cur[15:0];
        if (ok) exp_q.push_back(cur);
        @(posedge core_clk_i);
        cfg_we <= 1'b0;
    endtask
    task automatic sleep(input prs_sleep_e k);
        @(posedge core_clk_i);
        sleep_req <= 1'b1;
        sleep_kind <= k;
        @(posedge core_clk_i);
        sleep_req <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        #1;
    endtask
    // every config change must match the oldest note
    always @(posedge core_clk_i) begin
        #1;
        if ({cfg1, cfg0} !== prev) begin
            cmp_count++;
            if (exp_q.size() == 0 || exp_q.pop_front() !== {cfg1, cfg0}) begin
                failures++;
                $display("unexpected at %0t: config value", $time);
            end
            prev = {cfg1, cfg0};
        end
    end
    initial begin
        #400000;
        failures++;
        results();
    end
    initial begin
        repeat (3) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        cfg_wr(1'b0, 1'b0);
        wait_ready();
        sleep(PRS_SLP_NONE);
        chk(slp === PRS_SLP_NONE && ready === 1'b1);
        cfg_wr(1'b0, 1'b1);
        cfg_wr(1'b1, 1'b1);
        sleep(PRS_SLP_RETENTION);
        sleep(PRS_SLP_DEEPEST);
        chk(slp === PRS_SLP_RETENTION && ready === 1'b0);
        cur = 32'h00028F1F;
        exp_q.push_back(cur);
        @(posedge core_clk_i);
        reset_req <= 1'b1;
        @(posedge core_clk_i);
        reset_req <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        #1;
        chk(slp === PRS_SLP_NONE && ron === 1'b0 && aval === 1'b0 && row === 13'h0000);
        wait_ready();
        cfg_wr(1'b0, 1'b1);
        sleep(PRS_SLP_DEEPEST);
        chk(slp === PRS_SLP_DEEPEST && aval === 1'b0);
        chk(exp_q.size() == 0);
        results();
    end
endmodule
